// [hw/sacf_pkg.sv]
// Constants, field layout and state type for the converter control front.
// Assumes one 200 MHz system clock and an Avalon-MM slave with waitrequest.
// How it works
// - One of up to 28 inputs is chosen per conversion by the channel code.
// - Code 11010 routes the temperature sensor, code 11011 the bandgap reference.
// - Reserved codes still convert; the result value is then undefined.
// - Clock source is bus clock, bus clock half, local async clock or alternate clock.
// - Selected source is divided by a programmable factor to form the conversion clock.
// - Alternate clock keeps ticking the converter while the processor waits.
// - With hardware trigger on, each counter overflow starts one conversion.
// - Hardware trigger is honoured in run, wait and stop3.
// - Linear successive approximation resolves 12 bits, one decision per step.
// - Result is right justified unsigned, 12, 10 or 8 bits, upper bits zero.
// - Single or continuous conversion; single conversion returns to idle alone.
// - Completion sets a flag and, with interrupt enabled, raises an interrupt.
// - Optional compare against a value, less-than or greater-or-equal, gates the flag.
// - Sample time and speed versus power are configurable, with a long sample.
// - Converter keeps running in wait and stop3 with a suitable clock.
// - Channel field is 5 bits; codes 00000 to 01111 select external inputs 0 to 15.
// - All-ones code turns converter off, isolates input, stops continuous mode.
// - Writing control one aborts a conversion and, with hardware trigger off, restarts it unless the code is all ones.
`default_nettype none

package sacf_pkg;

  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned RES_BITS      = 12;
  localparam int unsigned CH_W          = 5;
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned DATA_W        = 32;

  // Channel codes
  localparam logic [4:0]  CH_TEMP       = 5'h1A;
  localparam logic [4:0]  CH_BANDGAP    = 5'h1B;
  localparam logic [4:0]  CH_OFF        = 5'h1F;

  // Register byte offsets
  localparam logic [4:0]  A_CTRL1       = 5'h00;
  localparam logic [4:0]  A_CTRL2       = 5'h04;
  localparam logic [4:0]  A_RESULT      = 5'h08;
  localparam logic [4:0]  A_CMP         = 5'h0C;
  localparam logic [4:0]  A_CFG         = 5'h10;

  // conversion_control_one fields
  localparam int unsigned C1_CH_LSB     = 0;
  localparam int unsigned C1_CONT       = 5;
  localparam int unsigned C1_IEN        = 6;
  localparam int unsigned C1_DONE       = 7;
  // control two fields
  localparam int unsigned C2_GTE        = 4;
  localparam int unsigned C2_CMPEN      = 5;
  localparam int unsigned C2_HWT        = 6;
  localparam int unsigned C2_ACTIVE     = 7;
  // configuration fields
  localparam int unsigned CFG_SRC_LSB   = 0;
  localparam int unsigned CFG_MODE_LSB  = 2;
  localparam int unsigned CFG_LSMP      = 4;
  localparam int unsigned CFG_DIV_LSB   = 5;
  localparam int unsigned CFG_LPWR      = 7;

  // Reset values
  localparam logic [4:0]  CH_RESET      = CH_OFF;
  localparam logic [11:0] CMP_RESET     = 12'h000;

  // Clock sources
  localparam logic [1:0]  SRC_BUS       = 2'h0;
  localparam logic [1:0]  SRC_BUS_HALF  = 2'h1;
  localparam logic [1:0]  SRC_ALT       = 2'h2;
  localparam logic [1:0]  SRC_LOCAL     = 2'h3;

  // Result widths
  localparam logic [1:0]  MODE_8        = 2'h0;
  localparam logic [1:0]  MODE_12       = 2'h1;
  localparam logic [1:0]  MODE_10       = 2'h2;
  localparam int unsigned SHIFT_10      = 2;
  localparam int unsigned SHIFT_8       = 4;

  // Sampling in conversion clock ticks
  localparam logic [4:0]  SHORT_SAMPLE  = 5'h03;
  localparam logic [4:0]  LONG_SAMPLE   = 5'h17;

  // Comparator settle time after each new trial code
  localparam int unsigned CMP_SETTLE_NS = 15;
  localparam int unsigned CMP_SETTLE_CYC_I = (CMP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0]  CMP_SETTLE_CYC = 2'(CMP_SETTLE_CYC_I);

  localparam logic [11:0] TRIAL_MSB     = 12'h800;
  localparam logic [3:0]  BIT_MSB       = 4'hB;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_STEP} sacf_state_t;

endpackage

`default_nettype wire

// [hw/sacf_sar.sv]
// Successive approximation sequencer: sampling phase, then one bit per step.
// Assumes tick is a one-cycle strobe from the conversion clock divider.
`default_nettype none

module sacf_sar
  import sacf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic        long_sample,
  input  wire logic        cmp_high,
  output logic             sample_q,
  output logic             busy_q,
  output logic             done_q,
  output logic [11:0]      trial_q,
  output logic [11:0]      raw_q
);

  sacf_state_t state_q;
  logic [4:0]  cnt_q;
  logic [3:0]  bit_q;
  logic [1:0]  settle_q;
  logic [11:0] bit_mask;
  logic [11:0] decided;

  assign bit_mask = 12'h001 << bit_q;
  // Keep the trial bit only when the input sits above the trial level
  assign decided  = cmp_high ? trial_q : (trial_q & ~bit_mask);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 5'h00;
      bit_q    <= 4'h0;
      settle_q <= 2'h0;
      sample_q <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      trial_q  <= 12'h000;
      raw_q    <= 12'h000;
    end else begin
      done_q <= 1'b0;
      if (settle_q != 2'h0) begin
        settle_q <= settle_q - 2'h1;
      end
      // A restart wins over an abort so a rewrite relaunches at once
      if (start) begin
        state_q  <= ST_SAMPLE;
        cnt_q    <= long_sample ? LONG_SAMPLE : SHORT_SAMPLE;
        sample_q <= 1'b1;
        busy_q   <= 1'b1;
      end else if (abort) begin
        state_q  <= ST_IDLE;
        sample_q <= 1'b0;
        busy_q   <= 1'b0;
      end else begin
        case (state_q)
          ST_SAMPLE: begin
            if (tick) begin
              if (cnt_q == 5'h00) begin
                sample_q <= 1'b0;
                trial_q  <= TRIAL_MSB;
                bit_q    <= BIT_MSB;
                settle_q <= CMP_SETTLE_CYC;
                state_q  <= ST_STEP;
              end else begin
                cnt_q <= cnt_q - 5'h01;
              end
            end
          end
          ST_STEP: begin
            if (tick && settle_q == 2'h0) begin
              if (bit_q == 4'h0) begin
                raw_q   <= decided;
                done_q  <= 1'b1;
                busy_q  <= 1'b0;
                state_q <= ST_IDLE;
              end else begin
                trial_q  <= decided | (bit_mask >> 1);
                bit_q    <= bit_q - 4'h1;
                settle_q <= CMP_SETTLE_CYC;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [hw/sacf_top.sv]
// Converter control front: register slave, clock source and divider,
// trigger handling, result formatting and compare.
// Assumes the analog mux, comparator and trial DAC sit outside; their
// comparator output and all clocks from outside arrive asynchronously.
//
// Implementation choices: the address map and the Avalon-MM slave port.
`default_nettype none

module sacf_top
  import sacf_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              hardware_trigger_input,
  input  wire logic              alternate_clock,
  input  wire logic              local_async_clock,
  input  wire logic              comparator_high,
  input  wire logic              stop3_mode,
  output logic      [4:0]        channel_select,
  output logic                   converter_on,
  output logic                   input_isolate,
  output logic                   temp_sensor_en,
  output logic                   bandgap_en,
  output logic                   low_power,
  output logic                   sample_hold,
  output logic      [11:0]       trial_code,
  output logic                   conversion_irq
);

  function automatic logic [11:0] fmt_result(input logic [11:0] raw, input logic [1:0] mode);
    logic [11:0] r;
    r = raw >> SHIFT_8;
    if (mode == MODE_12) begin
      r = raw;
    end else if (mode == MODE_10) begin
      r = raw >> SHIFT_10;
    end
    return r;
  endfunction

  function automatic logic [2:0] div_limit(input logic [1:0] sel);
    return 3'((4'h1 << sel) - 4'h1);
  endfunction

  // Software visible state
  logic [4:0]  ch_q;
  logic        cont_q;
  logic        ien_q;
  logic        done_q;
  logic        hwt_q;
  logic        cmpen_q;
  logic        gte_q;
  logic [11:0] cmpval_q;
  logic [11:0] result_q;
  logic [1:0]  src_q;
  logic [1:0]  mode_q;
  logic        lsmp_q;
  logic [1:0]  div_q;
  logic        lpwr_q;

  // Bus handshake
  logic        wait_q;
  logic        bus_go;
  logic        wr_c1;
  logic        wr_c2;
  logic        wr_cmp;
  logic        wr_cfg;
  logic        rd_result;
  logic [31:0] rd_word;

  // Synchronisers and clocking
  logic [2:0]  trig_s_q;
  logic [2:0]  alt_s_q;
  logic [2:0]  loc_s_q;
  logic [1:0]  cmp_s_q;
  logic        half_q;
  logic        src_tick;
  logic [2:0]  div_cnt_q;
  logic        conv_tick_q;
  logic        trig_pend_q;

  // Sequencer hookup
  logic        sar_start;
  logic        sar_busy;
  logic        sar_done;
  logic [11:0] sar_raw;
  logic        sw_start;
  logic        hw_start;
  logic        cont_start;
  logic [11:0] fmt_now;
  logic        cmp_true;
  logic [4:0]  wr_ch;

  assign bus_go = (avs_read || avs_write) && !wait_q;
  assign wr_ch  = avs_writedata[C1_CH_LSB +: CH_W];

  always_comb begin
    wr_c1     = 1'b0;
    wr_c2     = 1'b0;
    wr_cmp    = 1'b0;
    wr_cfg    = 1'b0;
    rd_result = 1'b0;
    rd_word   = 32'h0000_0000;
    if (avs_address == A_CTRL1) begin
      wr_c1   = avs_write && bus_go;
      rd_word = {24'h000000, done_q, ien_q, cont_q, ch_q};
    end else if (avs_address == A_CTRL2) begin
      wr_c2   = avs_write && bus_go;
      rd_word = {24'h000000, sar_busy, hwt_q, cmpen_q, gte_q, 4'h0};
    end else if (avs_address == A_RESULT) begin
      rd_result = avs_read && bus_go;
      rd_word   = {20'h00000, result_q};
    end else if (avs_address == A_CMP) begin
      wr_cmp  = avs_write && bus_go;
      rd_word = {20'h00000, cmpval_q};
    end else if (avs_address == A_CFG) begin
      wr_cfg  = avs_write && bus_go;
      rd_word = {24'h000000, lpwr_q, div_q, lsmp_q, mode_q, src_q};
    end
  end

  // One wait cycle per access; the access completes on the following edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_q       <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) begin
        avs_readdata <= rd_word;
      end
    end
  end

  assign avs_waitrequest = wait_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ch_q     <= CH_RESET;
      cont_q   <= 1'b0;
      ien_q    <= 1'b0;
      hwt_q    <= 1'b0;
      cmpen_q  <= 1'b0;
      gte_q    <= 1'b0;
      cmpval_q <= CMP_RESET;
      src_q    <= SRC_BUS;
      mode_q   <= MODE_8;
      lsmp_q   <= 1'b0;
      div_q    <= 2'h0;
      lpwr_q   <= 1'b0;
    end else begin
      if (wr_c1) begin
        ch_q   <= wr_ch;
        cont_q <= avs_writedata[C1_CONT];
        ien_q  <= avs_writedata[C1_IEN];
      end
      if (wr_c2) begin
        hwt_q   <= avs_writedata[C2_HWT];
        cmpen_q <= avs_writedata[C2_CMPEN];
        gte_q   <= avs_writedata[C2_GTE];
      end
      if (wr_cmp) begin
        cmpval_q <= avs_writedata[11:0];
      end
      if (wr_cfg) begin
        src_q  <= avs_writedata[CFG_SRC_LSB +: 2];
        mode_q <= avs_writedata[CFG_MODE_LSB +: 2];
        lsmp_q <= avs_writedata[CFG_LSMP];
        div_q  <= avs_writedata[CFG_DIV_LSB +: 2];
        lpwr_q <= avs_writedata[CFG_LPWR];
      end
    end
  end

  // Outside levels pass two flip-flops; stage three only feeds edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_s_q <= 3'h0;
      alt_s_q  <= 3'h0;
      loc_s_q  <= 3'h0;
      cmp_s_q  <= 2'h0;
    end else begin
      trig_s_q <= {trig_s_q[1:0], hardware_trigger_input};
      alt_s_q  <= {alt_s_q[1:0], alternate_clock};
      loc_s_q  <= {loc_s_q[1:0], local_async_clock};
      cmp_s_q  <= {cmp_s_q[0], comparator_high};
    end
  end

  // Bus-derived sources and the alternate clock halt in stop3; the local clock runs on. Wait mode gates nothing.
  always_comb begin
    case (src_q)
      SRC_BUS:      src_tick = !stop3_mode;
      SRC_BUS_HALF: src_tick = half_q && !stop3_mode;
      SRC_ALT:      src_tick = alt_s_q[1] && !alt_s_q[2] && !stop3_mode;
      default:      src_tick = loc_s_q[1] && !loc_s_q[2];
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      half_q      <= 1'b0;
      div_cnt_q   <= 3'h0;
      conv_tick_q <= 1'b0;
    end else begin
      half_q      <= !half_q;
      conv_tick_q <= 1'b0;
      if (src_tick) begin
        if (div_cnt_q >= div_limit(div_q)) begin
          div_cnt_q   <= 3'h0;
          conv_tick_q <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 3'h1;
        end
      end
    end
  end

  // An overflow edge is held until the sequencer is free, then used once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_pend_q <= 1'b0;
    end else begin
      if (hw_start || !hwt_q || ch_q == CH_OFF) begin
        trig_pend_q <= 1'b0;
      end
      if (trig_s_q[1] && !trig_s_q[2] && hwt_q && ch_q != CH_OFF) begin
        trig_pend_q <= 1'b1;
      end
    end
  end

  assign sw_start   = wr_c1 && wr_ch != CH_OFF && !hwt_q;
  // A trigger still pending when the off code lands must not relaunch the sequencer
  assign hw_start   = trig_pend_q && !sar_busy && !wr_c1 && ch_q != CH_OFF;
  assign cont_start = sar_done && cont_q && ch_q != CH_OFF && !hwt_q;
  assign sar_start  = sw_start || hw_start || cont_start;

  sacf_sar u_sar (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .tick        (conv_tick_q),
    .start       (sar_start),
    .abort       (wr_c1 || ch_q == CH_OFF),
    .long_sample (lsmp_q),
    .cmp_high    (cmp_s_q[1]),
    .sample_q    (sample_hold),
    .busy_q      (sar_busy),
    .done_q      (sar_done),
    .trial_q     (trial_code),
    .raw_q       (sar_raw)
  );

  assign fmt_now  = fmt_result(sar_raw, mode_q);
  assign cmp_true = gte_q ? (fmt_now >= cmpval_q) : (fmt_now < cmpval_q);

  // Clear first, then set, so a completion in the clearing cycle survives
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_q   <= 1'b0;
      result_q <= 12'h000;
    end else begin
      if (wr_c1 || rd_result) begin
        done_q <= 1'b0;
      end
      if (sar_done && (!cmpen_q || cmp_true)) begin
        done_q   <= 1'b1;
        result_q <= fmt_now;
      end
    end
  end

  // Analog side controls; reserved codes are passed through and convert anyway
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      channel_select <= CH_RESET;
      converter_on   <= 1'b0;
      input_isolate  <= 1'b1;
      temp_sensor_en <= 1'b0;
      bandgap_en     <= 1'b0;
      low_power      <= 1'b0;
      conversion_irq <= 1'b0;
    end else begin
      channel_select <= ch_q;
      converter_on   <= ch_q != CH_OFF;
      input_isolate  <= ch_q == CH_OFF;
      temp_sensor_en <= ch_q == CH_TEMP;
      bandgap_en     <= ch_q == CH_BANDGAP;
      low_power      <= lpwr_q;
      conversion_irq <= done_q && ien_q;
    end
  end

endmodule

`default_nettype wire

// [bench/sacf_top_props.sv]
// Checker for sacf_top: bus answer timing, channel decode and config outputs.
// Assumes it is bound to sacf_top and sees only its ports.
`default_nettype none

module sacf_top_props
  import sacf_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [4:0]        channel_select,
  input wire logic              converter_on,
  input wire logic              input_isolate,
  input wire logic              temp_sensor_en,
  input wire logic              bandgap_en,
  input wire logic              low_power,
  input wire logic              sample_hold
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic take_w;
  logic mapped;
  assign take_w = avs_write && !avs_waitrequest;
  assign mapped = avs_address inside {A_CTRL1, A_CTRL2, A_RESULT, A_CMP, A_CFG};

  a_isolate_code: assert property (input_isolate == (channel_select == CH_OFF))
    else $error("isolate does not follow the off code");
  a_power_code: assert property (converter_on != input_isolate)
    else $error("converter on while isolated");
  a_temp_code: assert property (temp_sensor_en == (channel_select == CH_TEMP))
    else $error("temperature route wrong");
  a_bgap_code: assert property (bandgap_en == (channel_select == CH_BANDGAP))
    else $error("bandgap route wrong");
  // Isolate lags the code by one cycle, so the cycle after a control one write is exempt
  a_off_idle: assert property (
    input_isolate && !$past(take_w && avs_address == A_CTRL1) |-> !sample_hold)
    else $error("sampling while switched off");
  // The register lands on the taking edge, the pin copy one edge later
  a_chan_write: assert property (
    take_w && avs_address == A_CTRL1 |-> ##2 channel_select == $past(avs_writedata[4:0], 2))
    else $error("channel code not taken");
  a_low_power: assert property (
    take_w && avs_address == A_CFG |-> ##2 low_power == $past(avs_writedata[CFG_LPWR], 2))
    else $error("low power bit not taken");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && !mapped |-> avs_readdata == '0)
    else $error("unmapped read not zero");
endmodule

`default_nettype wire

// [bench/sacf_analog_model.sv]
// Far side model: comparator against a held input level, overflow pulses
// and the two free-running outside clocks. Assumes trial_code drives the DAC.
`default_nettype none

module sacf_analog_model
(
  input  wire logic [11:0] trial_code,
  input  wire logic [11:0] analog_level,
  output logic             comparator_high,
  output logic             hardware_trigger_input,
  output logic             alternate_clock,
  output logic             local_async_clock
);
  timeunit 1ns;
  timeprecision 100ps;

  // Comparator settles after a short delay, not at once
  assign #3 comparator_high = (analog_level >= trial_code);

  initial begin
    hardware_trigger_input = 1'b0;
    alternate_clock = 1'b0;
    local_async_clock = 1'b0;
  end

  always #18.5 alternate_clock = ~alternate_clock;
  always #26.5 local_async_clock = ~local_async_clock;

  // One counter overflow, unrelated in phase to the system clock
  task automatic overflow();
    #7 hardware_trigger_input = 1'b1;
    #20 hardware_trigger_input = 1'b0;
  endtask
endmodule

`default_nettype wire

// [bench/sacf_top_tb.sv]
// Self-checking bench for sacf_top with an integer model of each result.
// Assumes the far side model and the props checker are compiled first.
`default_nettype none

module sacf_top_tb
  import sacf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest, stop3_mode;
  logic [4:0]  avs_address, channel_select;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [11:0] trial_code, level;
  logic        comparator_high, hardware_trigger_input, alternate_clock, local_async_clock;
  logic        converter_on, input_isolate, temp_sensor_en, bandgap_en, low_power, sample_hold, conversion_irq;
  int          bad_count, check_count, seed;

  always #2.5 clk_sys = ~clk_sys;

  sacf_analog_model u_pm (.trial_code(trial_code), .analog_level(level), .comparator_high(comparator_high),
    .hardware_trigger_input(hardware_trigger_input), .alternate_clock(alternate_clock),
    .local_async_clock(local_async_clock));

  sacf_top u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hardware_trigger_input(hardware_trigger_input),
    .alternate_clock(alternate_clock), .local_async_clock(local_async_clock),
    .comparator_high(comparator_high), .stop3_mode(stop3_mode), .channel_select(channel_select),
    .converter_on(converter_on), .input_isolate(input_isolate), .temp_sensor_en(temp_sensor_en),
    .bandgap_en(bandgap_en), .low_power(low_power), .sample_hold(sample_hold),
    .trial_code(trial_code), .conversion_irq(conversion_irq));

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_up(input string what);
    bad_count++;
    $display("wrong value at %0t: %s timed out", $time, what);
    conclude();
  endtask

  // Request held until the edge that sees waitrequest low; two idle edges after
  // so pin copies of the written registers have settled when the caller looks
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) give_up("bus answer");
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic wait_sh(input logic val);
    int n;
    n = 0;
    while (sample_hold !== val) begin
      @(posedge clk_sys);
      n++;
      if (n > 4000) give_up("sampling phase");
    end
  endtask

  // Polling is slow but needs no knowledge of the conversion length
  task automatic idle_wait();
    int n;
    n = 0;
    do begin
      bus(1'b0, A_CTRL2, 32'h0);
      n++;
      if (n > 3000) give_up("conversion end");
    end while (q[C2_ACTIVE] !== 1'b0);
    bus(1'b0, A_CTRL1, 32'h0);
  endtask

  function automatic logic [31:0] fmt(input int v, input logic [1:0] m);
    return (m == MODE_12) ? 32'(v) : (m == MODE_10) ? 32'(v >> SHIFT_10) : 32'(v >> SHIFT_8);
  endfunction

  initial begin
    logic [1:0]  md;
    logic [4:0]  ch;
    logic [31:0] cfg;
    int          v;
    seed = 33009;
    bad_count = 0;
    check_count = 0;
    clk_sys = 1'b0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    level = 12'h000;
    stop3_mode = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, A_CTRL1, 32'h0);
    chk(q, 32'h1F, "control one reset");
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0, "unmapped read");
    // Every source, divide and width; last two are bandgap then temperature
    for (int i = 0; i < 16; i++) begin
      md = (i % 3 == 0) ? MODE_12 : (i % 3 == 1) ? MODE_10 : MODE_8;
      v = $random(seed) & 4095;
      ch = (i == 13) ? 5'h1C : (i == 14) ? CH_BANDGAP : (i == 15) ? CH_TEMP : 5'($random(seed) & 15);
      cfg = 32'(i % 4) | (32'(md) << CFG_MODE_LSB) | (32'(i >= 14 || i[0]) << CFG_LSMP);
      cfg = cfg | (32'(i / 4) << CFG_DIV_LSB) | (32'(i[1]) << CFG_LPWR);
      level <= 12'(v);
      stop3_mode <= (i % 4 == 3);
      bus(1'b1, A_CFG, cfg);
      chk(32'(low_power), 32'(i[1]), "low power");
      bus(1'b1, A_CTRL1, 32'(ch) | (32'(i[0]) << C1_IEN));
      chk(32'(channel_select), 32'(ch), "channel");
      chk(32'({temp_sensor_en, bandgap_en}), 32'({ch == CH_TEMP, ch == CH_BANDGAP}), "route");
      idle_wait();
      chk(32'({q[C1_DONE], conversion_irq}), 32'({1'b1, i[0]}), "done and irq");
      bus(1'b0, A_RESULT, 32'h0);
      if (i != 13) chk(q, fmt(v, md), "result");
      bus(1'b0, A_CTRL1, 32'h0);
      chk(32'({q[C1_DONE], conversion_irq}), 32'h0, "done cleared by result read");
    end
    // Compare gate, equal value hit on both senses
    stop3_mode <= 1'b0;
    bus(1'b1, A_CFG, 32'(MODE_12) << CFG_MODE_LSB);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed) & 4095;
      cfg = (k < 2) ? 32'(v) : 32'($random(seed) & 4095);
      level <= 12'(v);
      bus(1'b1, A_CMP, cfg);
      bus(1'b1, A_CTRL2, (32'h1 << C2_CMPEN) | (32'(k[0]) << C2_GTE));
      bus(1'b1, A_CTRL1, 32'h03);
      idle_wait();
      chk(32'(q[C1_DONE]), 32'(k[0] ? (v >= int'(cfg)) : (v < int'(cfg))), "compare flag");
    end
    // Continuous hardware trigger on the local clock under stop3
    bus(1'b1, A_CTRL2, 32'h1 << C2_HWT);
    bus(1'b1, A_CFG, (32'(MODE_12) << CFG_MODE_LSB) | 32'(SRC_LOCAL));
    stop3_mode <= 1'b1;
    bus(1'b1, A_CTRL1, 32'h05 | (32'h1 << C1_CONT));
    repeat (100) @(posedge clk_sys);
    bus(1'b0, A_CTRL2, 32'h0);
    chk(32'(q[C2_ACTIVE]), 32'h0, "waits for trigger");
    for (int k = 0; k < 3; k++) begin
      v = $random(seed) & 4095;
      level <= 12'(v);
      u_pm.overflow();
      @(posedge clk_sys);
      wait_sh(1'b1);
      idle_wait();
      chk(32'(q[C1_DONE]), 32'h1, "triggered done");
      bus(1'b0, A_RESULT, 32'h0);
      chk(q, 32'(v), "triggered result");
      repeat (100) @(posedge clk_sys);
      bus(1'b0, A_CTRL2, 32'h0);
      chk(32'(q[C2_ACTIVE]), 32'h0, "one conversion per overflow");
    end
    // Software continuous run, then the off code stops it
    bus(1'b1, A_CTRL2, 32'h0);
    bus(1'b1, A_CTRL1, 32'h02 | (32'h1 << C1_CONT));
    wait_sh(1'b1);
    wait_sh(1'b0);
    wait_sh(1'b1);
    bus(1'b1, A_CTRL1, 32'h1F);
    chk(32'({converter_on, input_isolate}), 32'h1, "converter off");
    repeat (200) @(posedge clk_sys);
    bus(1'b0, A_CTRL2, 32'h0);
    chk(32'(q[C2_ACTIVE]), 32'h0, "no extra conversion");
    // Rewrite in mid-conversion restarts on the new level
    level <= 12'h0A5;
    bus(1'b1, A_CTRL1, 32'h04);
    wait_sh(1'b1);
    wait_sh(1'b0);
    level <= 12'hF3C;
    bus(1'b1, A_CTRL1, 32'h04);
    idle_wait();
    bus(1'b0, A_RESULT, 32'h0);
    chk(q, 32'hF3C, "restarted result");
    conclude();
  end
endmodule

bind sacf_top sacf_top_props u_props (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .channel_select(channel_select), .converter_on(converter_on),
  .input_isolate(input_isolate), .temp_sensor_en(temp_sensor_en), .bandgap_en(bandgap_en),
  .low_power(low_power), .sample_hold(sample_hold));

`default_nettype wire
